// ==== rtl/evr_consts.svh ====
// Constants for the program store verify read-out block
`ifndef EVR_CONSTS_SVH
`define EVR_CONSTS_SVH
`define EVR_ADDR_W 12
`define EVR_MEM_DEPTH 4096
`define EVR_KEY_DEPTH 32
`define EVR_KEY_IDX_W 5
`define EVR_SIG_ADDR_MAKER 12'h030
`define EVR_SIG_ADDR_PART 12'h031
// Arbitrary identity values, not those of any real part
`define EVR_SIG_MAKER 8'hA5
`define EVR_SIG_PART 8'h3C
`define EVR_ERASED 8'hFF
`define EVR_LOCK_OPEN 1'b0
`endif

// ==== rtl/evr_pkg.sv ====
// Types for the program store verify read-out block
package evr_pkg;
  typedef struct packed {
    logic [7:0] addrLow;
    logic [7:0] addrHigh;
    logic sigSelectLowA;
    logic sigSelectLowB;
  } evr_pins_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } evr_wr_t;
endpackage : evr_pkg

// ==== rtl/evr_sync3.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module evr_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] stable
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire logic [W-1:0] agreeMask = ~(s2_q ^ s3_q);
  wire logic [W-1:0] stable_d = (agreeMask & s3_q) | (~agreeMask & stable);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable <= stable_d;
    end
  end
endmodule : evr_sync3
`default_nettype wire

// ==== rtl/evr_verify_readout.sv ====
// Verify read-out of the program store: scrambling, signature bytes and lock gating
// Function
// - In verify mode port 0 shows the stored byte at the address given on ports 1 and 2.
// - Once the key table is written, reads return the XNOR of program byte and one key byte.
// - There is no direct path to read the key table; once it is written, an erased location reads its key byte.
// - Signature bytes read like locations 030H and 031H with both select pins low.
// - Signature location one gives a fixed maker code, location two a fixed part code.
// - An erased array reads all ones at every location until the key table is written.
// - Code verify reads are allowed only while the second lock bit is unprogrammed.
// - The key table holds 32 bytes at table addresses 0 to 1FH.
`timescale 1ns/1ps
`default_nettype none
`include "evr_consts.svh"
module evr_verify_readout
  import evr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire evr_pins_t pins,
  input wire logic verifyEn,
  input wire logic progWe,
  input wire evr_wr_t progWr,
  input wire logic keyWe,
  input wire logic [4:0] keyIdx,
  input wire logic [7:0] keyData,
  input wire logic lockTwoProgram,
  input wire logic eraseAll,
  output logic [7:0] port0Out,
  output logic port0Oe
);
  typedef enum logic [2:0] {
    EVR_IDLE = 3'b001,
    EVR_CODE = 3'b010,
    EVR_SIG = 3'b100
  } evr_state_t;

  localparam int PW = $bits(evr_pins_t);

  evr_pins_t pinsSync;
  logic [PW-1:0] pinsSyncRaw;

  // Storage cells have no reset, like the nonvolatile array they stand for
  logic [7:0] mem_q [`EVR_MEM_DEPTH];
  logic [7:0] key_q [`EVR_KEY_DEPTH];

  logic keyWritten_q;
  logic keyWritten_d;
  logic lockTwo_q;
  logic lockTwo_d;

  logic [15:0] fullAddr;
  logic [11:0] addr;
  logic sigMode;
  logic codeMode;
  logic readOpen;
  logic progOk;
  logic keyOk;
  logic wantSig;
  logic wantCode;

  logic [4:0] keySel;
  logic [7:0] rawByte;
  logic [7:0] keyByte;
  logic [7:0] xnorByte;
  logic [7:0] scrambled;
  logic hitMaker;
  logic hitPart;
  logic [7:0] sigByte;

  evr_state_t state_d;
  logic [7:0] port0Out_d;
  logic port0Oe_d;

  // Decode reads only the settled pin copy; a pin change reaches port 0 on the
  // fifth clock edge, so the programming system must hold pins at least that long
  evr_sync3 #(.W(PW)) uPinSync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(pins),
    .stable(pinsSyncRaw)
  );
  assign pinsSync = evr_pins_t'(pinsSyncRaw);

  assign fullAddr = {pinsSync.addrHigh, pinsSync.addrLow};
  // A 4K array leaves the upper port 2 bits out of the decode
  assign addr = fullAddr[11:0];

  assign sigMode = ~pinsSync.sigSelectLowA & ~pinsSync.sigSelectLowB;
  assign codeMode = pinsSync.sigSelectLowA & pinsSync.sigSelectLowB;

  assign readOpen = (lockTwo_q == `EVR_LOCK_OPEN);
  assign progOk = progWe && readOpen;
  assign keyOk = keyWe && readOpen;

  // Mixed select levels match neither mode and leave port 0 floating
  assign wantSig = verifyEn && sigMode;
  assign wantCode = verifyEn && codeMode && readOpen;

  assign keySel = addr[4:0];
  assign rawByte = mem_q[addr];
  assign keyByte = key_q[keySel];

  assign xnorByte = ~(rawByte ^ keyByte);
  assign scrambled = keyWritten_q ? xnorByte : rawByte;

  assign hitMaker = (addr == `EVR_SIG_ADDR_MAKER);
  assign hitPart = (addr == `EVR_SIG_ADDR_PART);
  assign sigByte = hitMaker ? `EVR_SIG_MAKER :
                   (hitPart ? `EVR_SIG_PART : `EVR_ERASED);

  // Signature reads ignore the lock so a locked part still identifies itself
  always_comb begin
    state_d = EVR_IDLE;
    if (wantSig) begin
      state_d = EVR_SIG;
    end else if (wantCode) begin
      state_d = EVR_CODE;
    end
  end

  always_comb begin
    unique case (state_d)
      EVR_CODE: port0Out_d = scrambled;
      EVR_SIG: port0Out_d = sigByte;
      default: port0Out_d = `EVR_ERASED;
    endcase
  end
  assign port0Oe_d = (state_d != EVR_IDLE);

  // A released port shows the pull-up level, so the idle value is all ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port0Out <= `EVR_ERASED;
    end else begin
      port0Out <= port0Out_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port0Oe <= 1'b0;
    end else begin
      port0Oe <= port0Oe_d;
    end
  end

  // Sticky flags: a set in the same cycle as an erase wins, though a key byte written in that cycle is still erased to all ones
  always_comb begin
    lockTwo_d = lockTwo_q;
    if (eraseAll) begin
      lockTwo_d = `EVR_LOCK_OPEN;
    end
    if (lockTwoProgram) begin
      lockTwo_d = ~`EVR_LOCK_OPEN;
    end
  end

  always_comb begin
    keyWritten_d = keyWritten_q;
    if (eraseAll) begin
      keyWritten_d = 1'b0;
    end
    if (keyOk) begin
      keyWritten_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockTwo_q <= `EVR_LOCK_OPEN;
    end else begin
      lockTwo_q <= lockTwo_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keyWritten_q <= 1'b0;
    end else begin
      keyWritten_q <= keyWritten_d;
    end
  end

  always_ff @(posedge clk) begin
    if (eraseAll) begin
      for (int i = 0; i < `EVR_MEM_DEPTH; i++) begin
        mem_q[i] <= `EVR_ERASED;
      end
    end else if (progOk) begin
      mem_q[progWr.addr] <= progWr.data;
    end
  end

  for (genvar g = 0; g < `EVR_KEY_DEPTH; g++) begin : gKey
    logic keyHit;
    assign keyHit = keyOk && (keyIdx == 5'(g));
    always_ff @(posedge clk) begin
      if (eraseAll) begin
        key_q[g] <= `EVR_ERASED;
      end else if (keyHit) begin
        key_q[g] <= keyData;
      end
    end
  end
endmodule : evr_verify_readout
`default_nettype wire

// ==== tb/evr_prog_sys.sv ====
// Programming system model: pin levels and unscrambling
`timescale 1ns/1ps
`default_nettype none
module evr_prog_sys
  import evr_pkg::*;
(
  input wire logic [11:0] addr,
  input wire logic [1:0] sel,
  input wire logic [7:0] key,
  input wire logic [7:0] d,
  input wire logic oe,
  output var evr_pins_t pins,
  output logic [7:0] plain
);
  assign pins = {addr[7:0], 4'h0, addr[11:8], sel};
  // Pull-ups: a floating port reads ones
  assign plain = ~((oe ? d : 8'hFF) ^ key);
endmodule : evr_prog_sys
`default_nettype wire

// ==== tb/evr_verify_readout_asserts.sv ====
// Port checks for the verify read-out block
`timescale 1ns/1ps
`default_nettype none
`include "evr_consts.svh"
module evr_verify_readout_asserts
  import evr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire evr_pins_t pins,
  input wire logic verifyEn,
  input wire logic lockTwoProgram,
  input wire logic eraseAll,
  input wire logic [7:0] port0Out,
  input wire logic port0Oe
);
  logic [2:0] cnt_q;
  logic lk_q;
  evr_pins_t pins_q;
  // Five steady cycles outlast the pin synchroniser
  wire rd = cnt_q > 3'h4;
  wire [1:0] sel = {pins.sigSelectLowA, pins.sigSelectLowB};
  wire [11:0] ad = {pins.addrHigh[3:0], pins.addrLow};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) {cnt_q, lk_q, pins_q} <= '0;
    else begin
      pins_q <= pins;
      lk_q <= lockTwoProgram | (lk_q & ~eraseAll);
      cnt_q <= verifyEn && pins == pins_q ? cnt_q + {2'h0, cnt_q != 3'h7} : 3'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_idle_off: assert property (!verifyEn |=> !port0Oe)
    else $error("idle drive");
  a_oe_cause: assert property (port0Oe |-> $past(verifyEn))
    else $error("oe cause");
  a_float_ones: assert property (!port0Oe |-> port0Out == 8'hFF)
    else $error("float value");
  a_maker_code: assert property (rd && sel == 2'h0 && ad == `EVR_SIG_ADDR_MAKER
    |-> port0Oe && port0Out == `EVR_SIG_MAKER) else $error("maker");
  a_part_code: assert property (rd && sel == 2'h0 && ad == `EVR_SIG_ADDR_PART
    |-> port0Oe && port0Out == `EVR_SIG_PART) else $error("part");
  a_sig_blank: assert property (rd && sel == 2'h0 && ad != `EVR_SIG_ADDR_MAKER
    && ad != `EVR_SIG_ADDR_PART |-> port0Oe && port0Out == `EVR_ERASED) else $error("sig blank");
  a_mixed_off: assert property (rd && ^sel |-> !port0Oe)
    else $error("mixed");
  a_code_on: assert property (rd && &sel && !lk_q && !$past(lk_q, 2) |-> port0Oe)
    else $error("code read");
  a_lock_off: assert property (rd && &sel && lk_q && $past(lk_q, 2) |-> !port0Oe)
    else $error("locked");
  c_sig: cover property (rd && sel == 2'h0 && port0Oe);
  c_lock: cover property (rd && lk_q && !port0Oe);
  c_code: cover property (rd && &sel && port0Oe);
endmodule : evr_verify_readout_asserts
bind evr_verify_readout evr_verify_readout_asserts evr_verify_readout_asserts_inst (
  .clk(clk), .rst_b(rst_b), .pins(pins), .verifyEn(verifyEn),
  .lockTwoProgram(lockTwoProgram), .eraseAll(eraseAll), .port0Out(port0Out),
  .port0Oe(port0Oe));
`default_nettype wire

// ==== tb/evr_verify_readout_test.sv ====
// Self-checking bench for the verify read-out block
`timescale 1ns/1ps
`default_nettype none
`include "evr_consts.svh"
module evr_verify_readout_test;
  logic clk = 1'b0, rst_b = 1'b0, verifyEn = 1'b0, progWe = 1'b0, keyWe = 1'b0;
  logic lockTwoProgram = 1'b0, eraseAll = 1'b0, port0Oe;
  logic [4:0] keyIdx = 5'h0;
  logic [7:0] keyData = 8'h0, key = 8'hFF, port0Out, plain;
  logic [11:0] addr = 12'h0;
  logic [1:0] sel = 2'h3;
  evr_pkg::evr_wr_t progWr = '0;
  evr_pkg::evr_pins_t pins;
  int mismatches = 0, n_tests = 0;
  always #50 clk = ~clk;
  evr_verify_readout evr_verify_readout_inst (.clk(clk), .rst_b(rst_b), .pins(pins),
    .verifyEn(verifyEn), .progWe(progWe), .progWr(progWr), .keyWe(keyWe), .keyIdx(keyIdx),
    .keyData(keyData), .lockTwoProgram(lockTwoProgram), .eraseAll(eraseAll),
    .port0Out(port0Out), .port0Oe(port0Oe));
  evr_prog_sys evr_prog_sys_inst (.addr(addr), .sel(sel), .key(key), .d(port0Out),
    .oe(port0Oe), .pins(pins), .plain(plain));
  task check(input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task end_sim();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  // Six cycles cover the five-edge answer of the synchronised pins
  task rd(input [11:0] a, input [1:0] s, input [7:0] e, input o);
    @(negedge clk) {addr, sel, verifyEn} = {a, s, 1'b1};
    repeat (6) @(negedge clk);
    check({port0Oe, port0Out}, {o, e});
    verifyEn = 1'b0;
  endtask : rd
  task t_erase();
    pulse(eraseAll);
    rd(12'h000, 2'h3, 8'hFF, 1'b1);
    rd(12'hFFF, 2'h3, 8'hFF, 1'b1);
  endtask : t_erase
  task t_write();
    @(negedge clk) {progWe, progWr} = {1'b1, 12'h123, 8'h5A};
    @(negedge clk) progWr = {12'hFFF, 8'hC3};
    @(negedge clk) progWe = 1'b0;
    rd(12'h123, 2'h3, 8'h5A, 1'b1);
    rd(12'hFFF, 2'h3, 8'hC3, 1'b1);
  endtask : t_write
  task t_sig();
    rd(`EVR_SIG_ADDR_MAKER, 2'h0, `EVR_SIG_MAKER, 1'b1);
    rd(`EVR_SIG_ADDR_PART, 2'h0, `EVR_SIG_PART, 1'b1);
    rd(12'h123, 2'h1, 8'hFF, 1'b0);
  endtask : t_sig
  task t_key();
    for (int i = 0; i < 32; i++) begin
      @(negedge clk) {keyWe, keyIdx, keyData} = {1'b1, i[4:0], 3'h5, i[4:0]};
    end
    @(negedge clk) keyWe = 1'b0;
    key = 8'hBF;
    rd(12'hFFF, 2'h3, ~(8'hC3 ^ 8'hBF), 1'b1);
    check({1'b0, plain}, 9'h0C3);
    key = 8'hA3;
    rd(12'h123, 2'h3, ~(8'h5A ^ 8'hA3), 1'b1);
    check({1'b0, plain}, 9'h05A);
    rd(12'h000, 2'h0, 8'hFF, 1'b1);
  endtask : t_key
  task t_lock();
    pulse(lockTwoProgram);
    rd(12'h123, 2'h3, 8'hFF, 1'b0);
    rd(`EVR_SIG_ADDR_PART, 2'h0, `EVR_SIG_PART, 1'b1);
    pulse(eraseAll);
    rd(12'h123, 2'h3, 8'hFF, 1'b1);
  endtask : t_lock
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_erase();
    t_write();
    t_sig();
    t_key();
    t_lock();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : evr_verify_readout_test
`default_nettype wire
